// ### src/tah_pkg.sv
package tah_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_AVG = 8'h04;
  localparam logic [7:0] ADR_PTIME = 8'h08;
  localparam logic [7:0] ADR_PPCT = 8'h0C;
  localparam logic [7:0] ADR_SPAN = 8'h10;
  localparam logic [7:0] ADR_OFFS = 8'h14;
  localparam logic [7:0] ADR_OLO = 8'h18;
  localparam logic [7:0] ADR_OHI = 8'h1C;
  localparam logic [7:0] ADR_ALM1 = 8'h20;
  localparam logic [7:0] ADR_ALM2 = 8'h30;
  localparam logic [1:0] ALM_MODE = 2'h0;
  localparam logic [1:0] ALM_HYST = 2'h1;
  localparam logic [1:0] ALM_LOW = 2'h2;
  localparam logic [1:0] ALM_HIGH = 2'h3;
  localparam logic [7:0] ADR_LOCK = 8'h40;
  localparam logic [7:0] ADR_NEWCODE = 8'h44;
  localparam logic [7:0] ADR_CONFIRM = 8'h48;
  localparam logic [7:0] ADR_CMD = 8'h4C;
  localparam logic [7:0] ADR_STATUS = 8'h50;
  localparam logic [7:0] ADR_TEMP = 8'h54;
  localparam logic [7:0] ADR_AOUT = 8'h58;

  // ==========================================================================
  // field positions
  localparam int CTRL_PEAK_EN = 0;
  localparam int CTRL_DISCH = 1;
  localparam int CTRL_OUT_HOLD = 2;
  localparam int CTRL_POL = 3;
  localparam int CTRL_TYPE = 5;
  localparam int CTRL_SCHED = 8;
  localparam int CTRL_DISP_HOLD = 9;
  localparam int CMD_ACK = 0;
  localparam int CMD_RESET = 1;
  localparam int CMD_LOG_GO = 2;
  localparam int CMD_LOG_STOP = 3;
  localparam int CMD_REF_CLR = 4;
  localparam int LOCK_UNLOCK = 16;
  localparam int LOCK_LOCK = 17;

  // ==========================================================================
  // reset values
  localparam logic [9:0] CTRL_RST = 10'h200;
  localparam logic [15:0] AVG_RST = 16'h0032;
  localparam logic [15:0] PTIME_RST = 16'h03E8;
  localparam logic [6:0] PPCT_RST = 7'h50;
  localparam logic [15:0] SPAN_RST = 16'h0100;
  localparam logic [15:0] OLO_RST = 16'h0000;
  localparam logic [15:0] OHI_RST = 16'h1388;
  localparam logic [15:0] HYST_RST = 16'h000A;
  localparam logic [15:0] ALOW_RST = 16'h0000;
  localparam logic [15:0] AHIGH_RST = 16'h03E8;
  localparam logic [15:0] CODE_RST = 16'h1234;

  // ==========================================================================
  // scaling constants
  localparam logic [15:0] PCT_RECIP = 16'h028F;
  localparam logic [15:0] DEG_RECIP = 16'h199A;
  localparam logic [15:0] LIVE_ZERO = 16'h3333;
  localparam logic [15:0] LIVE_GAIN = 16'hCCCC;

  // ==========================================================================
  // modes
  typedef enum logic [2:0] {
    TAH_HIGH_ON, TAH_HIGH_OFF, TAH_LOW_ON, TAH_LOW_OFF,
    TAH_BAND_ON, TAH_BAND_OFF, TAH_ERR_ON, TAH_ERR_OFF
  } tah_amode_t;
  typedef enum logic [2:0] {
    TAH_OUT_4_20, TAH_OUT_0_20, TAH_OUT_VOLT, TAH_OUT_MV, TAH_OUT_OFF
  } tah_otype_t;
  typedef enum logic [1:0] {TAH_POL_NONE, TAH_POL_UPPER, TAH_POL_LOWER} tah_pol_t;

endpackage

// ### src/tah_alarm_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tah_alarm_if;
  logic [15:0] temp;
  logic fault;
  logic [2:0] mode;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] hyst;
  logic active;
  modport cfg(output temp, fault, mode, lo, hi, hyst, input active);
  modport eval(input temp, fault, mode, lo, hi, hyst, output active);
endinterface
`default_nettype wire

// ### src/tah_alarm_eval.sv
`timescale 1ns/100ps
`default_nettype none
module tah_alarm_eval (
  input wire logic clk_i,
  input wire logic rst_i,
  tah_alarm_if.eval alm
);

  typedef struct packed {
    logic h_above;
    logic l_above;
    logic active;
  } tah_aev_t;

  tah_aev_t s_r;
  tah_aev_t s_nxt;
  logic signed [17:0] t;
  logic signed [17:0] half;
  logic signed [17:0] hi_on;
  logic signed [17:0] hi_off;
  logic signed [17:0] lo_on;
  logic signed [17:0] lo_off;

  // ==========================================================================
  // hysteresis comparators, band centred on each setpoint
  always_comb begin
    t = 18'(signed'(alm.temp));
    half = signed'({3'h0, alm.hyst[15:1]});
    hi_on = 18'(signed'(alm.hi)) + half;
    hi_off = 18'(signed'(alm.hi)) - half;
    lo_on = 18'(signed'(alm.lo)) + half;
    lo_off = 18'(signed'(alm.lo)) - half;
    s_nxt = s_r;
    if (t > hi_on) begin
      s_nxt.h_above = 1'b1;
    end else if (t < hi_off) begin
      s_nxt.h_above = 1'b0;
    end
    if (t > lo_on) begin
      s_nxt.l_above = 1'b1;
    end else if (t < lo_off) begin
      s_nxt.l_above = 1'b0;
    end
    case (tah_pkg::tah_amode_t'(alm.mode))
      tah_pkg::TAH_HIGH_ON: s_nxt.active = s_nxt.h_above;
      tah_pkg::TAH_HIGH_OFF: s_nxt.active = ~s_nxt.h_above;
      tah_pkg::TAH_LOW_ON: s_nxt.active = ~s_nxt.l_above;
      tah_pkg::TAH_LOW_OFF: s_nxt.active = s_nxt.l_above;
      tah_pkg::TAH_BAND_ON: s_nxt.active = s_nxt.l_above & ~s_nxt.h_above;
      tah_pkg::TAH_BAND_OFF: s_nxt.active = ~s_nxt.l_above | s_nxt.h_above;
      tah_pkg::TAH_ERR_ON: s_nxt.active = alm.fault;
      tah_pkg::TAH_ERR_OFF: s_nxt.active = ~alm.fault;
      default: s_nxt.active = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign alm.active = s_r.active;

endmodule
`default_nettype wire

// ### src/tah_processor.sv
// Behaviour
// - high-on alarm active above high setpoint; high-off active below it
// - low-on alarm active below low setpoint; low-off active above it
// - band-on active between setpoints; band-off active outside them
// - error-on active during voltage fault; error-off active without fault
// - hysteresis band of configured width is centred on each setpoint
// - two alarms, each with its own mode, setpoints and hysteresis
// - acknowledge drops relays, keeps red indication, no retrigger until reset
// - acknowledge works while settings are locked
// - red indication whenever any alarm is activated
// - four-digit code lock, default 1234, code changeable after confirmation
// - time hold snaps back to live temperature when hold period ends
// - discharge hold decays to set percentage of temperature over period
// - discharge percentage ignored in time hold mode
// - peak hold bypassed unless enabled
// - averaging period selectable, 50 ms after reset
// - span multiplies temperature slope, offset is added
// - output type 4-20 mA default, 0-20 mA, voltage, mV per degree, off
// - output linear between lower and upper limit temperatures
// - output source raw or hold, independent of display choice
// - on voltage fault output untreated, forced upper or forced lower
// - manual log start refused while scheduled start is enabled
`timescale 1ns/100ps
`default_nettype none
module tah_processor #(
  parameter int MS_CYCLES = tah_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [15:0] temp_i,
  input wire logic temp_valid_i,
  input wire logic fault_i,
  output logic [1:0] relay_o,
  output logic alarm_red_o,
  output logic [15:0] aout_code_o,
  output logic [2:0] aout_type_o,
  output logic logging_o,
  output logic [15:0] disp_temp_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [9:0] ctrl;
    logic [15:0] avg_ms;
    logic [15:0] ptime;
    logic [6:0] ppct;
    logic [15:0] span;
    logic [15:0] offs;
    logic [15:0] olo;
    logic [15:0] ohi;
    logic [1:0][2:0] amode;
    logic [1:0][15:0] ahyst;
    logic [1:0][15:0] alo;
    logic [1:0][15:0] ahi;
    logic [15:0] code;
    logic [15:0] pend;
    logic locked;
    logic [1:0] latched;
    logic [1:0] acked;
    logic [1:0] relay;
    logic red;
    logic logging;
    logic log_ref;
    logic [15:0] mscnt;
    logic [15:0] corr;
    logic [15:0] avgv;
    logic [15:0] hold;
    logic [15:0] tgt;
    logic [15:0] dstep;
    logic [15:0] ptmr;
    logic [31:0] bacc;
    logic dbusy;
    logic [3:0] dcnt;
    logic [17:0] drem;
    logic [16:0] dden;
    logic [15:0] dq;
    logic [15:0] frac;
    logic [15:0] aout;
    logic [15:0] disp;
  } tah_st_t;

  tah_st_t q;
  tah_st_t s;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] wd, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] lg2(logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] sat16(logic signed [39:0] v);
    if (v > 40'sd32767) begin
      return 16'h7FFF;
    end else if (v < -40'sd32768) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  function automatic logic [15:0] pct_of(logic [15:0] x, logic [6:0] p);
    logic signed [39:0] m;
    m = 40'(signed'(x)) * 40'(p) * 40'(tah_pkg::PCT_RECIP);
    return sat16(m >>> 16);
  endfunction

  function automatic logic [15:0] scale(logic [2:0] ty, logic [1:0] pol, logic flt,
                                        logic [15:0] fr, logic [15:0] t);
    logic [15:0] f;
    logic [31:0] p;
    logic signed [39:0] mv;
    logic forced;
    forced = flt && (tah_pkg::tah_pol_t'(pol) != tah_pkg::TAH_POL_NONE);
    f = fr;
    if (flt && tah_pkg::tah_pol_t'(pol) == tah_pkg::TAH_POL_UPPER) begin
      f = 16'hFFFF;
    end else if (flt && tah_pkg::tah_pol_t'(pol) == tah_pkg::TAH_POL_LOWER) begin
      f = 16'h0000;
    end
    p = 32'(f) * 32'(tah_pkg::LIVE_GAIN);
    mv = signed'(40'(signed'(t)) * 40'(tah_pkg::DEG_RECIP)) >>> 16;
    case (tah_pkg::tah_otype_t'(ty))
      tah_pkg::TAH_OUT_4_20: return tah_pkg::LIVE_ZERO + p[31:16];
      tah_pkg::TAH_OUT_0_20: return f;
      tah_pkg::TAH_OUT_VOLT: return f;
      tah_pkg::TAH_OUT_MV: return forced ? f : (mv < 0 ? 16'h0000 : sat16(mv));
      default: return 16'h0000;
    endcase
  endfunction

  // ==========================================================================
  // alarm evaluators
  tah_alarm_if ai[2]();
  logic [1:0] act;

  for (genvar g = 0; g < 2; g++) begin : g_alm
    assign ai[g].temp = q.hold;
    assign ai[g].fault = fault_i;
    assign ai[g].mode = q.amode[g];
    assign ai[g].lo = q.alo[g];
    assign ai[g].hi = q.ahi[g];
    assign ai[g].hyst = q.ahyst[g];
    assign act[g] = ai[g].active;
    tah_alarm_eval u_eval (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .alm(ai[g])
    );
  end

  // ==========================================================================
  // next state
  logic [7:0] a;
  logic req;
  logic wr;
  logic cfg_wr;
  logic [31:0] rv;
  logic [31:0] wv;
  logic tick;
  logic ack_cmd;
  logic rst_cmd;
  logic go_cmd;
  logic refused;
  logic [16:0] diff;
  logic [31:0] nper;
  logic [31:0] bsum;
  logic [15:0] src;
  logic signed [16:0] num;
  logic signed [16:0] den;
  logic [17:0] rem2;
  logic ai_sel;

  always_comb begin
    s = q;
    a = {wb_adr_i[7:2], 2'b00};
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = req & wb_we_i;
    cfg_wr = wr & ~q.locked;
    ai_sel = a[4];
    // ---- read view, also the base for byte-lane merges
    rv = 32'h0000_0000;
    case (a)
      tah_pkg::ADR_CTRL: rv = {22'h0, q.ctrl};
      tah_pkg::ADR_AVG: rv = {16'h0, q.avg_ms};
      tah_pkg::ADR_PTIME: rv = {16'h0, q.ptime};
      tah_pkg::ADR_PPCT: rv = {25'h0, q.ppct};
      tah_pkg::ADR_SPAN: rv = {16'h0, q.span};
      tah_pkg::ADR_OFFS: rv = {16'h0, q.offs};
      tah_pkg::ADR_OLO: rv = {16'h0, q.olo};
      tah_pkg::ADR_OHI: rv = {16'h0, q.ohi};
      tah_pkg::ADR_LOCK: rv = {31'h0, q.locked};
      tah_pkg::ADR_STATUS: rv = {21'h0, fault_i, q.log_ref, q.logging, q.locked,
                                 q.acked, q.latched, q.red, q.relay};
      tah_pkg::ADR_TEMP: rv = {q.hold, q.corr};
      tah_pkg::ADR_AOUT: rv = {16'h0, q.aout};
      default: begin
        if (a[7:5] == tah_pkg::ADR_ALM1[7:5]) begin
          case (a[3:2])
            tah_pkg::ALM_MODE: rv = {29'h0, q.amode[ai_sel]};
            tah_pkg::ALM_HYST: rv = {16'h0, q.ahyst[ai_sel]};
            tah_pkg::ALM_LOW: rv = {16'h0, q.alo[ai_sel]};
            default: rv = {16'h0, q.ahi[ai_sel]};
          endcase
        end
      end
    endcase
    wv = wmerge(rv, wb_dat_i, wb_sel_i);
    // ---- bus answer
    s.ack = req;
    if (req & ~wb_we_i) begin
      s.rdat = rv;
    end
    // ---- settings writes, refused while locked
    if (cfg_wr) begin
      case (a)
        tah_pkg::ADR_CTRL: s.ctrl = wv[9:0];
        tah_pkg::ADR_AVG: s.avg_ms = wv[15:0];
        tah_pkg::ADR_PTIME: s.ptime = wv[15:0];
        tah_pkg::ADR_PPCT: s.ppct = wv[6:0];
        tah_pkg::ADR_SPAN: s.span = wv[15:0];
        tah_pkg::ADR_OFFS: s.offs = wv[15:0];
        tah_pkg::ADR_OLO: s.olo = wv[15:0];
        tah_pkg::ADR_OHI: s.ohi = wv[15:0];
        tah_pkg::ADR_NEWCODE: s.pend = wv[15:0];
        tah_pkg::ADR_CONFIRM: begin
          if (wv[15:0] == q.pend) begin
            s.code = q.pend;
          end
        end
        default: begin
          if (a[7:5] == tah_pkg::ADR_ALM1[7:5]) begin
            case (a[3:2])
              tah_pkg::ALM_MODE: s.amode[ai_sel] = wv[2:0];
              tah_pkg::ALM_HYST: s.ahyst[ai_sel] = wv[15:0];
              tah_pkg::ALM_LOW: s.alo[ai_sel] = wv[15:0];
              default: s.ahi[ai_sel] = wv[15:0];
            endcase
          end
        end
      endcase
    end
    // ---- lock control, always reachable
    if (wr && a == tah_pkg::ADR_LOCK) begin
      if (wv[tah_pkg::LOCK_LOCK]) begin
        s.locked = 1'b1;
      end else if (wv[tah_pkg::LOCK_UNLOCK] && wv[15:0] == q.code) begin
        s.locked = 1'b0;
      end
    end
    // ---- commands, accepted even while locked
    ack_cmd = wr && a == tah_pkg::ADR_CMD && wv[tah_pkg::CMD_ACK];
    rst_cmd = wr && a == tah_pkg::ADR_CMD && wv[tah_pkg::CMD_RESET];
    go_cmd = wr && a == tah_pkg::ADR_CMD && wv[tah_pkg::CMD_LOG_GO];
    refused = go_cmd & q.ctrl[tah_pkg::CTRL_SCHED];
    if (go_cmd & ~refused) begin
      s.logging = 1'b1;
    end else if (wr && a == tah_pkg::ADR_CMD && wv[tah_pkg::CMD_LOG_STOP]) begin
      s.logging = 1'b0;
    end
    s.log_ref = refused |
                (q.log_ref & ~(wr && a == tah_pkg::ADR_CMD && wv[tah_pkg::CMD_REF_CLR]));
    // ---- alarm latching, new activation beats a reset
    s.latched = act | (q.latched & ~{2{rst_cmd}});
    s.acked = (q.acked & ~{2{rst_cmd}}) | ((q.latched | act) & {2{ack_cmd}});
    s.relay = act & ~s.acked;
    s.red = |s.latched;
    // ---- millisecond tick
    tick = (q.mscnt == 16'(MS_CYCLES - 1));
    s.mscnt = tick ? 16'h0000 : q.mscnt + 16'h0001;
    // ---- correction and averaging
    if (temp_valid_i) begin
      s.corr = sat16((signed'(40'(signed'(temp_i)) * 40'(q.span)) >>> 8) +
                     40'(signed'(q.offs)));
    end
    diff = 17'(signed'(q.corr)) - 17'(signed'(q.avgv));
    if (tick) begin
      s.avgv = q.avgv + 16'(signed'(diff) >>> lg2(q.avg_ms));
    end
    // ---- peak hold
    nper = 32'(q.ptime) * 32'(MS_CYCLES);
    bsum = q.bacc + 32'(q.dstep);
    if (~q.ctrl[tah_pkg::CTRL_PEAK_EN]) begin
      s.hold = q.avgv;
      s.ptmr = 16'h0000;
      s.bacc = 32'h0000_0000;
    end else if (signed'(q.avgv) >= signed'(q.hold)) begin
      s.hold = q.avgv;
      s.ptmr = 16'h0000;
      s.bacc = 32'h0000_0000;
      s.tgt = pct_of(q.avgv, q.ppct);
      s.dstep = (signed'(q.avgv) > signed'(s.tgt)) ? q.avgv - s.tgt : 16'h0000;
    end else begin
      if (tick && q.ptmr < q.ptime) begin
        s.ptmr = q.ptmr + 16'h0001;
      end
      if (q.ptmr >= q.ptime) begin
        s.hold = q.avgv;
      end else if (q.ctrl[tah_pkg::CTRL_DISCH]) begin
        if (bsum >= nper) begin
          s.bacc = bsum - nper;
          if (signed'(q.hold) > signed'(q.tgt)) begin
            s.hold = q.hold - 16'h0001;
          end
        end else begin
          s.bacc = bsum;
        end
      end
    end
    // ---- output scaling by serial division
    src = q.ctrl[tah_pkg::CTRL_OUT_HOLD] ? q.hold : q.corr;
    num = 17'(signed'(src)) - 17'(signed'(q.olo));
    den = 17'(signed'(q.ohi)) - 17'(signed'(q.olo));
    rem2 = {q.drem[16:0], 1'b0};
    if (~q.dbusy) begin
      if (den <= 0 || num <= 0) begin
        s.frac = 16'h0000;
      end else if (num >= den) begin
        s.frac = 16'hFFFF;
      end else begin
        s.dbusy = 1'b1;
        s.dcnt = 4'h0;
        s.drem = 18'(num);
        s.dden = 17'(den);
      end
    end else begin
      if (rem2 >= 18'(q.dden)) begin
        s.drem = rem2 - 18'(q.dden);
        s.dq = {q.dq[14:0], 1'b1};
      end else begin
        s.drem = rem2;
        s.dq = {q.dq[14:0], 1'b0};
      end
      s.dcnt = q.dcnt + 4'h1;
      if (q.dcnt == 4'hF) begin
        s.dbusy = 1'b0;
        s.frac = s.dq;
      end
    end
    s.aout = scale(q.ctrl[tah_pkg::CTRL_TYPE +: 3], q.ctrl[tah_pkg::CTRL_POL +: 2],
                   fault_i, q.frac, src);
    s.disp = q.ctrl[tah_pkg::CTRL_DISP_HOLD] ? q.hold : q.corr;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= tah_pkg::CTRL_RST;
      q.avg_ms <= tah_pkg::AVG_RST;
      q.ptime <= tah_pkg::PTIME_RST;
      q.ppct <= tah_pkg::PPCT_RST;
      q.span <= tah_pkg::SPAN_RST;
      q.olo <= tah_pkg::OLO_RST;
      q.ohi <= tah_pkg::OHI_RST;
      q.ahyst <= {tah_pkg::HYST_RST, tah_pkg::HYST_RST};
      q.alo <= {tah_pkg::ALOW_RST, tah_pkg::ALOW_RST};
      q.ahi <= {tah_pkg::AHIGH_RST, tah_pkg::AHIGH_RST};
      q.code <= tah_pkg::CODE_RST;
      q.locked <= 1'b1;
    end else begin
      q <= s;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign relay_o = q.relay;
  assign alarm_red_o = q.red;
  assign aout_code_o = q.aout;
  assign aout_type_o = q.ctrl[tah_pkg::CTRL_TYPE +: 3];
  assign logging_o = q.logging;
  assign disp_temp_o = q.disp;

endmodule
`default_nettype wire

// ### test/tah_processor_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tah_processor_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [1:0] relay_o,
  input wire logic alarm_red_o,
  input wire logic [2:0] aout_type_o,
  input wire logic logging_o
);
  // ======
  // taken requests
  logic req;
  logic cw;
  logic ctw;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cw = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == tah_pkg::ADR_CMD);
  assign ctw = req & wb_we_i & (wb_adr_i == tah_pkg::ADR_CTRL);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ======
  // bus answer
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("request not answered");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  dat_keep_a: assert property (!$stable(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data moved outside a read");
  // ======
  // alarms and outputs
  relay_red_a: assert property (
    relay_o != 2'h0 |-> alarm_red_o) else $error("relay on without red");
  red_keep_a: assert property (
    alarm_red_o && !(cw && wb_dat_i[1]) && !$past(cw && wb_dat_i[1])
    && !$past(cw && wb_dat_i[1], 2) && !$past(cw && wb_dat_i[1], 3) |=> alarm_red_o)
    else $error("red dropped without reset command");
  ack_drop_a: assert property (
    cw && wb_dat_i[0] && !wb_dat_i[1] |-> ##[1:4] relay_o == 2'h0)
    else $error("relays kept after acknowledge");
  log_cause_a: assert property (
    $rose(logging_o) |-> $past(cw && wb_dat_i[2]) || $past(cw && wb_dat_i[2], 2)
    || $past(cw && wb_dat_i[2], 3)) else $error("logging started without command");
  type_cause_a: assert property (
    !$stable(aout_type_o) |-> $past(ctw) || $past(ctw, 2))
    else $error("output type moved without control write");
endmodule
bind tah_processor tah_processor_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .relay_o(relay_o), .alarm_red_o(alarm_red_o),
  .aout_type_o(aout_type_o), .logging_o(logging_o));
`default_nettype wire

// ### test/tah_temp_source.sv
`timescale 1ns/100ps
`default_nettype none
module tah_temp_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] temp_set_i,
  input wire logic fault_set_i,
  output logic [15:0] temp_o,
  output logic temp_valid_o,
  output logic fault_o
);
  // ======
  // sample every fourth cycle, bus scrambled between samples
  logic [1:0] div_r;
  always_ff @(posedge clk_i) begin
    div_r <= rst_i ? 2'h0 : div_r + 2'h1;
    temp_valid_o <= !rst_i && div_r == 2'h3;
    temp_o <= (div_r == 2'h3) ? temp_set_i : ~temp_set_i;
    fault_o <= fault_set_i;
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h seen %h", n, e, g); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dout;
  logic [15:0] tset = 16'h0000;
  logic fset = 1'b0;
  logic [15:0] temp;
  logic [15:0] aout;
  logic [15:0] disp;
  logic tval, flt, ack, red, logg;
  logic [1:0] rel;
  logic [2:0] atype;
  logic [7:0] ex [2] = '{8'h9A, 8'h5A};
  int n_mismatch = 0;
  int checks = 0;
  always #20 clk_i = ~clk_i;
  tah_temp_source u_src (.clk_i(clk_i), .rst_i(rst_i), .temp_set_i(tset), .fault_set_i(fset),
    .temp_o(temp), .temp_valid_o(tval), .fault_o(flt));
  tah_processor #(.MS_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(dout), .temp_i(temp), .temp_valid_i(tval), .fault_i(flt),
    .relay_o(rel), .alarm_red_o(red), .aout_code_o(aout), .aout_type_o(atype),
    .logging_o(logg), .disp_temp_o(disp));
  // ======
  // bus access and checks
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK("read", e, rdat)
  endtask
  task automatic st(input logic [1:0] e);
    repeat (150) @(posedge clk_i);
    `CHK("relay", e, rel)
  endtask
  function automatic logic [7:0] af(input logic [7:0] b, input logic [1:0] f);
    return b + {4'h0, f, 2'h0};
  endfunction
  task automatic results();
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ======
  // scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(tah_pkg::ADR_CTRL, 32'h200);
    rdc(tah_pkg::ADR_AVG, 32'h32);
    rdc(tah_pkg::ADR_STATUS, 32'h80);
    wr(tah_pkg::ADR_AVG, 32'h1);
    rdc(tah_pkg::ADR_AVG, 32'h32);
    wr(tah_pkg::ADR_LOCK, 32'h11111);
    rdc(tah_pkg::ADR_LOCK, 32'h1);
    wr(tah_pkg::ADR_LOCK, 32'h11234);
    rdc(tah_pkg::ADR_LOCK, 32'h0);
    wr(tah_pkg::ADR_NEWCODE, 32'h4321);
    wr(tah_pkg::ADR_CONFIRM, 32'h4321);
    wr(tah_pkg::ADR_LOCK, 32'h20000);
    wr(tah_pkg::ADR_LOCK, 32'h11234);
    rdc(tah_pkg::ADR_LOCK, 32'h1);
    wr(tah_pkg::ADR_LOCK, 32'h14321);
    rdc(tah_pkg::ADR_LOCK, 32'h0);
    wr(tah_pkg::ADR_AVG, 32'h1);
    wr(af(tah_pkg::ADR_ALM2, tah_pkg::ALM_HIGH), 32'h7D0);
    tset <= 16'h03EC;
    st(2'h0);
    tset <= 16'h03EE;
    st(2'h1);
    `CHK("red", 1'b1, red)
    tset <= 16'h03E4;
    st(2'h1);
    tset <= 16'h03E2;
    st(2'h0);
    `CHK("disp", 16'h03E2, disp)
    wr(tah_pkg::ADR_CMD, 32'h2);
    st(2'h0);
    `CHK("red", 1'b0, red)
    wr(tah_pkg::ADR_OFFS, 32'h5);
    st(2'h0);
    `CHK("disp", 16'h03E7, disp)
    wr(af(tah_pkg::ADR_ALM1, tah_pkg::ALM_LOW), 32'hC8);
    wr(af(tah_pkg::ADR_ALM1, tah_pkg::ALM_HIGH), 32'h320);
    tset <= 16'h01F4;
    for (int f = 0; f < 2; f++) begin
      fset <= f[0];
      for (int m = 0; m < 8; m++) begin
        wr(af(tah_pkg::ADR_ALM1, tah_pkg::ALM_MODE), 32'(m));
        st({1'b0, ex[f][m]});
      end
    end
    fset <= 1'b0;
    wr(af(tah_pkg::ADR_ALM1, tah_pkg::ALM_MODE), 32'h0);
    tset <= 16'h0384;
    st(2'h1);
    wr(tah_pkg::ADR_LOCK, 32'h20000);
    wr(tah_pkg::ADR_CMD, 32'h1);
    st(2'h0);
    `CHK("red", 1'b1, red)
    wr(tah_pkg::ADR_CMD, 32'h2);
    st(2'h1);
    wr(tah_pkg::ADR_LOCK, 32'h14321);
    wr(tah_pkg::ADR_CTRL, 32'h300);
    wr(tah_pkg::ADR_CMD, 32'h4);
    repeat (4) @(posedge clk_i);
    `CHK("log", 1'b0, logg)
    wr(tah_pkg::ADR_CTRL, 32'h200);
    wr(tah_pkg::ADR_CMD, 32'h4);
    repeat (4) @(posedge clk_i);
    `CHK("log", 1'b1, logg)
    wr(tah_pkg::ADR_CMD, 32'h8);
    repeat (4) @(posedge clk_i);
    `CHK("log", 1'b0, logg)
    tset <= 16'h09BF;
    wr(tah_pkg::ADR_CTRL, 32'h220);
    st(2'h3);
    `CHK("aout", 16'h8000, aout)
    wr(tah_pkg::ADR_PTIME, 32'h5);
    wr(tah_pkg::ADR_CTRL, 32'h225);
    tset <= 16'h04DD;
    repeat (45) @(posedge clk_i);
    `CHK("disp", 16'h09C4, disp)
    `CHK("aout", 16'h8000, aout)
    st(2'h1);
    `CHK("disp", 16'h04E2, disp)
    `CHK("aout", 16'h4000, aout)
    wr(tah_pkg::ADR_SPAN, 32'h200);
    st(2'h3);
    rdc(tah_pkg::ADR_TEMP, 32'h09BF09BF);
    fset <= 1'b1;
    for (int t = 0; t < 5; t++) begin
      wr(tah_pkg::ADR_CTRL, 32'h210 | (32'(t) << 5));
      repeat (40) @(posedge clk_i);
      `CHK("type", 3'(t), atype)
      if (t == 1) `CHK("aout", 16'h0000, aout)
    end
    wr(tah_pkg::ADR_CTRL, 32'h228);
    repeat (40) @(posedge clk_i);
    `CHK("aout", 16'hFFFF, aout)
    results();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
